// ---- rtl/srs_params.svh ----
// constants of the status reporting block
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
// bit positions in the two sub-registers
`define SRS_LIM1_BIT 0
`define SRS_LIM2_BIT 1
`define SRS_OVL_BIT 2
// bits that may ever be set; bit 15 never
`define SRS_LIM_VALID 16'h0003
`define SRS_POW_VALID 16'h0004
// reset and preset fills
`define SRS_PTR_FILL 16'hffff
`define SRS_NTR_FILL 16'h0000
`define SRS_EN_FILL 16'h0000
`define SRS_SRE_RESET 8'h00
// status byte bits that may raise a request
`define SRS_SRQ_MASK 8'hbc
`define SRS_STB_MSS_BIT 6
// no-error code returned from an empty queue
`define SRS_NO_ERROR 16'h0000
`define SRS_ERRQ_DEPTH 8
// operation codes on the command port
`define SRS_OP_NONE 5'h00
`define SRS_OP_RD_COND 5'h01
`define SRS_OP_RD_EVT 5'h02
`define SRS_OP_RD_EN 5'h03
`define SRS_OP_RD_PTR 5'h04
`define SRS_OP_RD_NTR 5'h05
`define SRS_OP_WR_EN 5'h06
`define SRS_OP_WR_PTR 5'h07
`define SRS_OP_WR_NTR 5'h08
`define SRS_OP_STAT_PRE 5'h09
`define SRS_OP_CLS 5'h0a
`define SRS_OP_RST 5'h0b
`define SRS_OP_SYS_PRE 5'h0c
`define SRS_OP_DCL 5'h0d
`define SRS_OP_RD_STB 5'h0e
`define SRS_OP_WR_SRE 5'h0f
`define SRS_OP_RD_SRE 5'h10
`define SRS_OP_RD_ERR 5'h11
`endif

// ---- rtl/srs_pkg.sv ----
// types of the status reporting block
package srs_pkg;
`include "srs_params.svh"
    typedef enum logic [4:0] {
        SRS_NONE = `SRS_OP_NONE,
        SRS_RD_COND = `SRS_OP_RD_COND,
        SRS_RD_EVT = `SRS_OP_RD_EVT,
        SRS_RD_EN = `SRS_OP_RD_EN,
        SRS_RD_PTR = `SRS_OP_RD_PTR,
        SRS_RD_NTR = `SRS_OP_RD_NTR,
        SRS_WR_EN = `SRS_OP_WR_EN,
        SRS_WR_PTR = `SRS_OP_WR_PTR,
        SRS_WR_NTR = `SRS_OP_WR_NTR,
        SRS_STAT_PRE = `SRS_OP_STAT_PRE,
        SRS_CLS = `SRS_OP_CLS,
        SRS_RST = `SRS_OP_RST,
        SRS_SYS_PRE = `SRS_OP_SYS_PRE,
        SRS_DCL = `SRS_OP_DCL,
        SRS_RD_STB = `SRS_OP_RD_STB,
        SRS_WR_SRE = `SRS_OP_WR_SRE,
        SRS_RD_SRE = `SRS_OP_RD_SRE,
        SRS_RD_ERR = `SRS_OP_RD_ERR
    } srs_op_t;
    typedef struct packed {
        srs_op_t op;
        logic sel;
        logic [15:0] data;
    } srs_cmd_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } srs_rsp_t;
    typedef struct packed {
        logic if_ovl;
        logic lim2;
        logic lim1;
    } srs_cond_t;
endpackage

// ---- rtl/srs_status.sv ----
// questionable limit/power sub-registers, error queue and service request
`timescale 1ns/1ps
// offsets, fills and op codes shared with the package
`include "srs_params.svh"
module srs_status #(
    parameter int ERRQ_DEPTH = `SRS_ERRQ_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pon_clear,
    input wire logic cmd_valid,
    input wire srs_pkg::srs_cmd_t cmd,
    input wire logic cmd_first,
    input wire logic spoll_req,
    input wire srs_pkg::srs_cond_t cond,
    input wire logic err_push,
    input wire logic [15:0] err_code,
    input wire logic obuf_avail,
    input wire logic esb_sum,
    input wire logic oper_sum,
    input wire logic ques_other_sum,
    output srs_pkg::srs_rsp_t rsp,
    output logic srq,
    output logic flush_obuf,
    output logic flush_ibuf,
    output logic settings_reset,
    output logic overload_indicator_text
);
    import srs_pkg::*;

    localparam int NSUB = 2;
    localparam int PW = $clog2(ERRQ_DEPTH);

    // the queue pointers wrap by overflow, so only powers of two work
    generate
        if (ERRQ_DEPTH < 2 || (ERRQ_DEPTH & (ERRQ_DEPTH - 1)) != 0) begin : g_chk
            $error("ERRQ_DEPTH must be a power of two of at least 2");
        end
    endgenerate

    // command decode, shared by all state groups
    logic op_go;
    logic stat_pre;
    logic cls_do;
    logic pon_ff;
    logic nxt_pon;
    logic psc_do;
    logic preset_do;
    logic clear_do;
    assign op_go = cmd_valid;
    assign stat_pre = op_go && cmd.op == SRS_STAT_PRE;
    assign cls_do = op_go && cmd.op == SRS_CLS;
    assign psc_do = pon_ff && pon_clear;
    assign preset_do = psc_do || stat_pre;
    assign clear_do = psc_do || cls_do;

    // condition inputs placed at their bit positions
    logic [15:0] cond_in [NSUB];
    always_comb begin
        cond_in[0] = 16'h0000;
        cond_in[1] = 16'h0000;
        cond_in[0][`SRS_LIM1_BIT] = cond.lim1;
        cond_in[0][`SRS_LIM2_BIT] = cond.lim2;
        cond_in[1][`SRS_OVL_BIT] = cond.if_ovl;
    end

    logic [15:0] cond_ff [NSUB];
    logic [15:0] evt_ff [NSUB];
    logic [15:0] ptr_ff [NSUB];
    logic [15:0] ntr_ff [NSUB];
    logic [15:0] en_ff [NSUB];
    logic [NSUB-1:0] sum;

    // one sub-register per pass: condition, filters, event, enable
    genvar g;
    generate
        for (g = 0; g < NSUB; g++) begin : g_sub
            localparam logic [15:0] VM = (g == 0) ? `SRS_LIM_VALID : `SRS_POW_VALID;
            logic hit;
            logic [15:0] nxt_cond;
            logic [15:0] nxt_evt;
            logic [15:0] nxt_ptr;
            logic [15:0] nxt_ntr;
            logic [15:0] nxt_en;
            logic [15:0] edges;
            assign hit = op_go && cmd.sel == 1'(g);
            always_comb begin
                nxt_cond = cond_in[g] & VM;
                edges = (nxt_cond & ~cond_ff[g] & ptr_ff[g])
                    | (~nxt_cond & cond_ff[g] & ntr_ff[g]);
                nxt_evt = evt_ff[g];
                if (clear_do || (hit && cmd.op == SRS_RD_EVT)) begin
                    nxt_evt = 16'h0000;
                end
                // a fresh edge wins over the clear of the same cycle
                nxt_evt = (nxt_evt | edges) & VM;
                nxt_ptr = ptr_ff[g];
                nxt_ntr = ntr_ff[g];
                nxt_en = en_ff[g];
                if (preset_do) begin
                    nxt_ptr = `SRS_PTR_FILL;
                    nxt_ntr = `SRS_NTR_FILL;
                    nxt_en = `SRS_EN_FILL;
                end else if (hit) begin
                    case (cmd.op)
                        SRS_WR_EN: nxt_en = cmd.data;
                        SRS_WR_PTR: nxt_ptr = cmd.data;
                        SRS_WR_NTR: nxt_ntr = cmd.data;
                        default: nxt_en = en_ff[g];
                    endcase
                end
            end
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cond_ff[g] <= 16'h0000;
                    evt_ff[g] <= 16'h0000;
                    ptr_ff[g] <= `SRS_PTR_FILL;
                    ntr_ff[g] <= `SRS_NTR_FILL;
                    en_ff[g] <= `SRS_EN_FILL;
                end else begin
                    cond_ff[g] <= nxt_cond;
                    evt_ff[g] <= nxt_evt;
                    ptr_ff[g] <= nxt_ptr;
                    ntr_ff[g] <= nxt_ntr;
                    en_ff[g] <= nxt_en;
                end
            end
            assign sum[g] = |(evt_ff[g] & en_ff[g]);
        end
    endgenerate

    // error queue; a full queue drops the newest entry
    logic [15:0] errq_ff [ERRQ_DEPTH];
    logic [15:0] nxt_errq [ERRQ_DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic [PW-1:0] nxt_wr;
    logic [PW-1:0] nxt_rd;
    logic [PW:0] nxt_cnt;
    logic err_pop;
    logic err_nempty;
    assign err_nempty = cnt_ff != '0;
    assign err_pop = op_go && cmd.op == SRS_RD_ERR && err_nempty;
    always_comb begin
        nxt_errq = errq_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        // power-on in either state empties the queue
        if (pon_ff || cls_do) begin
            nxt_wr = '0;
            nxt_rd = '0;
            nxt_cnt = '0;
        end else if (err_pop) begin
            nxt_rd = rd_ff + 1'b1;
            nxt_cnt = cnt_ff - 1'b1;
        end
        // push after the clear so a same-cycle clear never drops a new error
        if (err_push && nxt_cnt != (PW+1)'(ERRQ_DEPTH)) begin
            nxt_errq[nxt_wr] = err_code;
            nxt_wr = nxt_wr + 1'b1;
            nxt_cnt = nxt_cnt + 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ERRQ_DEPTH; i++) begin
                errq_ff[i] <= 16'h0000;
            end
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            errq_ff <= nxt_errq;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // status byte, request enable and service request
    logic [7:0] sre_ff;
    logic [7:0] nxt_sre;
    logic [7:0] stb;
    logic nxt_srq;
    logic ques_sum;
    assign ques_sum = sum[0] | sum[1] | ques_other_sum;
    always_comb begin
        // bits 1:0 have no source here and read as zero
        stb = {oper_sum, srq, esb_sum, obuf_avail, ques_sum, err_nempty, 2'h0};
        nxt_sre = sre_ff;
        if (psc_do) begin
            nxt_sre = `SRS_SRE_RESET;
        end else if (op_go && cmd.op == SRS_WR_SRE) begin
            nxt_sre = cmd.data[7:0];
        end
        nxt_srq = |(stb & sre_ff & `SRS_SRQ_MASK);
    end

    // query answers, one cycle after the request
    srs_rsp_t nxt_rsp;
    logic [7:0] poll_stb;
    always_comb begin
        poll_stb = stb;
        poll_stb[`SRS_STB_MSS_BIT] = srq;
        nxt_rsp = '0;
        nxt_rsp.valid = spoll_req;
        nxt_rsp.data = {8'h00, poll_stb};
        if (op_go) begin
            nxt_rsp.valid = 1'b1;
            case (cmd.op)
                SRS_RD_COND: nxt_rsp.data = cond_ff[cmd.sel];
                SRS_RD_EVT: nxt_rsp.data = evt_ff[cmd.sel];
                SRS_RD_EN: nxt_rsp.data = en_ff[cmd.sel];
                SRS_RD_PTR: nxt_rsp.data = ptr_ff[cmd.sel];
                SRS_RD_NTR: nxt_rsp.data = ntr_ff[cmd.sel];
                SRS_RD_STB: nxt_rsp.data = {8'h00, poll_stb};
                SRS_RD_SRE: nxt_rsp.data = {8'h00, sre_ff};
                SRS_RD_ERR: nxt_rsp.data = err_nempty ? errq_ff[rd_ff] : `SRS_NO_ERROR;
                default: nxt_rsp.valid = spoll_req;
            endcase
        end
    end

    // buffer flushing, settings reset and the one-shot power-on step
    logic arm_ff;
    logic nxt_arm;
    logic nxt_fob;
    logic nxt_fib;
    logic nxt_setr;
    logic dcl_do;
    logic arm_set;
    logic nxt_ovl;
    assign dcl_do = op_go && cmd.op == SRS_DCL;
    assign arm_set = op_go && (cmd.op == SRS_RST || cmd.op == SRS_SYS_PRE
        || cmd.op == SRS_STAT_PRE || cmd.op == SRS_CLS);
    always_comb begin
        nxt_pon = 1'b0;
        // indicator copies the overload condition, one cycle late
        nxt_ovl = cond.if_ovl;
        nxt_fib = pon_ff || dcl_do;
        nxt_fob = nxt_fib;
        nxt_arm = arm_ff;
        // device clear leaves settings alone
        nxt_setr = op_go && (cmd.op == SRS_RST || cmd.op == SRS_SYS_PRE);
        if (arm_set) begin
            nxt_arm = 1'b1;
        end else if (cmd_valid && cmd_first && arm_ff) begin
            nxt_arm = 1'b0;
            nxt_fob = 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pon_ff <= 1'b1;
            sre_ff <= `SRS_SRE_RESET;
            srq <= 1'b0;
            rsp <= '0;
            arm_ff <= 1'b0;
            flush_obuf <= 1'b0;
            flush_ibuf <= 1'b0;
            settings_reset <= 1'b0;
            overload_indicator_text <= 1'b0;
        end else begin
            pon_ff <= nxt_pon;
            sre_ff <= nxt_sre;
            srq <= nxt_srq;
            rsp <= nxt_rsp;
            arm_ff <= nxt_arm;
            flush_obuf <= nxt_fob;
            flush_ibuf <= nxt_fib;
            settings_reset <= nxt_setr;
            overload_indicator_text <= nxt_ovl;
        end
    end
endmodule

// ---- test/srs_status_properties.sv ----
// concurrent checks for the status reporting block
`timescale 1ns/1ps
module srs_status_chk #(
    parameter int ERRQ_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire srs_pkg::srs_cmd_t cmd,
    input wire logic spoll_req,
    input wire srs_pkg::srs_cond_t cond,
    input wire srs_pkg::srs_rsp_t rsp,
    input wire logic flush_obuf,
    input wire logic flush_ibuf,
    input wire logic settings_reset,
    input wire logic overload_indicator_text
);
    import srs_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // a query taken on this edge
    sequence s_query;
        cmd_valid && cmd.op inside {SRS_RD_COND, SRS_RD_EVT, SRS_RD_EN, SRS_RD_PTR,
            SRS_RD_NTR, SRS_RD_STB, SRS_RD_SRE, SRS_RD_ERR};
    endsequence
    // condition read of one sub-register
    sequence s_cond_rd(s);
        cmd_valid && cmd.op == SRS_RD_COND && cmd.sel == s;
    endsequence
    a_query_answer: assert property (s_query |=> rsp.valid)
        else $error("query got no answer");
    a_poll_answer: assert property (spoll_req |=> rsp.valid)
        else $error("serial poll got no answer");
    a_write_silent: assert property (cmd_valid && cmd.op == SRS_WR_EN && !spoll_req
        |=> !rsp.valid)
        else $error("write produced an answer");
    a_limit_unused: assert property (s_cond_rd(1'b0) |=> rsp.data[15:2] == 14'h0)
        else $error("limit unused bits set");
    a_power_unused: assert property (s_cond_rd(1'b1)
        |=> rsp.data[15:3] == 13'h0 && rsp.data[1:0] == 2'h0)
        else $error("power unused bits set");
    a_limit_follows: assert property (s_cond_rd(1'b0) ##0 $stable(cond)
        |=> rsp.data[1:0] == {$past(cond.lim2), $past(cond.lim1)})
        else $error("limit condition mismatch");
    a_dcl_flush: assert property (cmd_valid && cmd.op == SRS_DCL
        |=> flush_obuf && flush_ibuf)
        else $error("device clear did not flush");
    a_settings_reset: assert property (cmd_valid && cmd.op inside {SRS_RST, SRS_SYS_PRE}
        |=> settings_reset)
        else $error("reset did not touch settings");
    a_settings_kept: assert property (settings_reset
        |-> $past(cmd_valid) && $past(cmd.op) inside {SRS_RST, SRS_SYS_PRE})
        else $error("settings touched without reset");
    a_overload_shown: assert property ($rose(cond.if_ovl) |=> overload_indicator_text)
        else $error("overload not shown");
endmodule
bind srs_status srs_status_chk #(.ERRQ_DEPTH(ERRQ_DEPTH)) u_chk (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .spoll_req(spoll_req),
    .cond(cond), .rsp(rsp), .flush_obuf(flush_obuf), .flush_ibuf(flush_ibuf),
    .settings_reset(settings_reset), .overload_indicator_text(overload_indicator_text)
);

// ---- test/srs_ctrl_model.sv ----
// remote controller model: commands and serial polls
`timescale 1ns/1ps
module srs_ctrl_model (
    input wire logic mclk,
    output logic cmd_valid,
    output srs_pkg::srs_cmd_t cmd,
    output logic cmd_first,
    output logic spoll_req
);
    import srs_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        cmd_first = 1'b0;
        spoll_req = 1'b0;
    end
    // one request per call; data inverted once released so stale values never match
    task automatic issue(input srs_op_t op, input logic sel, input logic [15:0] d,
        input logic first, input logic poll);
        @(negedge mclk);
        cmd_valid = !poll;
        cmd = '{op, sel, d};
        cmd_first = first;
        spoll_req = poll;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd = '{SRS_NONE, ~sel, ~d};
        cmd_first = 1'b0;
        spoll_req = 1'b0;
    endtask
endmodule

// ---- test/test_srs_status.sv ----
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module test_srs_status;
    import srs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pon_clear = 1'b0;
    logic cmd_valid, cmd_first, spoll_req, srq, flush_obuf, flush_ibuf, settings_reset, ovl_ind;
    srs_cmd_t cmd;
    srs_rsp_t rsp;
    srs_cond_t cond = '0;
    logic err_push = 1'b0;
    logic [15:0] err_code = '0;
    logic obuf_avail = 1'b0, esb_sum = 1'b0, oper_sum = 1'b0, ques_other_sum = 1'b0;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    srs_op_t act[5] = '{SRS_DCL, SRS_RST, SRS_SYS_PRE, SRS_STAT_PRE, SRS_CLS};
    always #25 mclk = ~mclk;
    srs_ctrl_model ctl (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_first(cmd_first),
        .spoll_req(spoll_req));
    srs_status dut (.mclk(mclk), .rst(rst), .pon_clear(pon_clear), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_first(cmd_first), .spoll_req(spoll_req), .cond(cond),
        .err_push(err_push), .err_code(err_code), .obuf_avail(obuf_avail), .esb_sum(esb_sum),
        .oper_sum(oper_sum), .ques_other_sum(ques_other_sum), .rsp(rsp), .srq(srq),
        .flush_obuf(flush_obuf), .flush_ibuf(flush_ibuf), .settings_reset(settings_reset),
        .overload_indicator_text(ovl_ind));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic w(input srs_op_t op, input logic sel, input logic [15:0] d);
        ctl.issue(op, sel, d, 1'b0, 1'b0);
    endtask
    // answer is taken while it stands, right after the request drops
    task automatic qc(input string nm, input srs_op_t op, input logic sel, input logic [15:0] e);
        w(op, sel, 16'h0000);
        chk("rsp_valid", {15'h0, rsp.valid}, 16'h0001);
        chk(nm, rsp.data, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic do_reset(input logic pc);
        pon_clear = pc;
        rst = 1'b1;
        idle(6);
        rst = 1'b0;
        idle(1);
        // the power-on step flushes both buffers one cycle after release
        chk("pon_flush_o", {15'h0, flush_obuf}, 16'h0001);
        chk("pon_flush_i", {15'h0, flush_ibuf}, 16'h0001);
        idle(1);
    endtask
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard; the whole run needs about 140 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        do_reset(1'b0);
        for (int s = 0; s < 2; s++) begin
            qc("ptr", SRS_RD_PTR, s[0], 16'hffff);
            qc("ntr", SRS_RD_NTR, s[0], 16'h0000);
            qc("en", SRS_RD_EN, s[0], 16'h0000);
        end
        cond = 3'h1;
        idle(1);
        qc("lim_cond", SRS_RD_COND, 1'b0, 16'h0001);
        cond = 3'h7;
        idle(1);
        qc("lim_cond", SRS_RD_COND, 1'b0, 16'h0003);
        qc("pow_cond", SRS_RD_COND, 1'b1, 16'h0004);
        chk("ovl_ind", {15'h0, ovl_ind}, 16'h0001);
        qc("lim_evt", SRS_RD_EVT, 1'b0, 16'h0003);
        qc("lim_evt", SRS_RD_EVT, 1'b0, 16'h0000);
        qc("pow_evt", SRS_RD_EVT, 1'b1, 16'h0004);
        // falls pass only where the negative filter is open
        w(SRS_WR_NTR, 1'b1, 16'hffff);
        cond = 3'h0;
        idle(1);
        qc("pow_evt", SRS_RD_EVT, 1'b1, 16'h0004);
        qc("lim_evt", SRS_RD_EVT, 1'b0, 16'h0000);
        w(SRS_WR_SRE, 1'b0, 16'h00ff);
        w(SRS_WR_EN, 1'b0, 16'h0001);
        cond = 3'h1;
        idle(3);
        chk("srq", {15'h0, srq}, 16'h0001);
        qc("lim_evt", SRS_RD_EVT, 1'b0, 16'h0001);
        idle(2);
        chk("srq", {15'h0, srq}, 16'h0000);
        // each of the four level inputs alone raises the request and shows in both reads
        for (int b = 3; b < 8; b++) begin
            if (b == 6) continue;
            {oper_sum, esb_sum, obuf_avail, ques_other_sum} = 4'h1 << (b == 7 ? 3 : b - 3);
            idle(2);
            chk("srq", {15'h0, srq}, 16'h0001);
            ctl.issue(SRS_NONE, 1'b0, 16'h0000, 1'b0, 1'b1);
            chk("poll", rsp.data, 16'h0040 | (16'h0001 << b));
            qc("stb", SRS_RD_STB, 1'b0, 16'h0040 | (16'h0001 << b));
            {oper_sum, esb_sum, obuf_avail, ques_other_sum} = 4'h0;
        end
        for (int i = 1; i < 3; i++) begin
            @(negedge mclk);
            err_code = 16'h8000 | i[15:0];
            err_push = 1'b1;
            @(negedge mclk);
            err_push = 1'b0;
        end
        idle(2);
        chk("srq", {15'h0, srq}, 16'h0001);
        qc("err", SRS_RD_ERR, 1'b0, 16'h8001);
        qc("err", SRS_RD_ERR, 1'b0, 16'h8002);
        qc("err", SRS_RD_ERR, 1'b0, 16'h0000);
        // a set source whose enable bit is off must not raise the request
        w(SRS_WR_SRE, 1'b0, 16'h00f7);
        ques_other_sum = 1'b1;
        idle(2);
        chk("srq_masked", {15'h0, srq}, 16'h0000);
        qc("sre", SRS_RD_SRE, 1'b0, 16'h00f7);
        ques_other_sum = 1'b0;
        // clear status drops pending events and arms the output drop
        cond = 3'h0;
        idle(1);
        cond = 3'h1;
        idle(1);
        w(SRS_CLS, 1'b0, 16'h0000);
        ctl.issue(SRS_RD_EVT, 1'b0, 16'h0000, 1'b1, 1'b0);
        chk("evt_cls", rsp.data, 16'h0000);
        chk("drop", {15'h0, flush_obuf}, 16'h0001);
        ctl.issue(SRS_RD_EVT, 1'b0, 16'h0000, 1'b1, 1'b0);
        chk("drop_once", {15'h0, flush_obuf}, 16'h0000);
        foreach (act[k]) begin
            w(act[k], 1'b0, 16'h0000);
            chk("flush_o", {15'h0, flush_obuf}, {15'h0, act[k] == SRS_DCL});
            chk("flush_i", {15'h0, flush_ibuf}, {15'h0, act[k] == SRS_DCL});
            chk("settings", {15'h0, settings_reset},
                {15'h0, act[k] inside {SRS_RST, SRS_SYS_PRE}});
        end
        w(SRS_WR_PTR, 1'b1, 16'h0000);
        w(SRS_WR_EN, 1'b1, 16'h00ff);
        w(SRS_STAT_PRE, 1'b0, 16'h0000);
        qc("ptr", SRS_RD_PTR, 1'b1, 16'hffff);
        qc("en", SRS_RD_EN, 1'b1, 16'h0000);
        qc("ntr", SRS_RD_NTR, 1'b1, 16'h0000);
        do_reset(1'b1);
        qc("sre", SRS_RD_SRE, 1'b0, 16'h0000);
        close_out();
    end
endmodule
